// [rtl/upic_pkg.sv]
// upic_pkg: register map, field positions, reset values, states and
// helpers for the usb power and interrupt-enable control block.
// assumes a 32-bit apb slave with word-aligned registers.
package upic_pkg;

  // register byte offsets
  localparam logic [11:0] UPIC_PWR_CTRL_OFF = 12'h000;
  localparam logic [11:0] UPIC_IRQ_EN_OFF   = 12'h004;
  localparam logic [11:0] UPIC_IRQ_STAT_OFF = 12'h008;
  localparam logic [11:0] UPIC_MODE_OFF     = 12'h00C;

  // usb_power_control fields
  localparam int unsigned UPIC_PWR_ON_BIT = 0;
  localparam int unsigned UPIC_SUSP_BIT   = 1;
  localparam int unsigned UPIC_BUSY_BIT   = 3;
  localparam int unsigned UPIC_GUARD_BIT  = 4;
  localparam int unsigned UPIC_PEND_BIT   = 7;

  // usb_interrupt_enable / status fields
  localparam int unsigned UPIC_EVT_W      = 8;
  localparam int unsigned UPIC_STALL_BIT  = 7;
  localparam int unsigned UPIC_ATTACH_BIT = 6;
  localparam int unsigned UPIC_RESUME_BIT = 5;
  localparam int unsigned UPIC_IDLE_BIT   = 4;
  localparam int unsigned UPIC_TOKEN_BIT  = 3;
  localparam int unsigned UPIC_SOF_BIT    = 2;
  localparam int unsigned UPIC_ERR_BIT    = 1;
  localparam int unsigned UPIC_RST_BIT    = 0;

  // mode register field
  localparam int unsigned UPIC_HOST_BIT = 0;

  // reset values
  localparam logic [7:0] UPIC_EVT_RST = 8'h00;
  localparam logic       UPIC_BIT_RST = 1'b0;

  // cycles from power-off until the module may be enabled again
  localparam int unsigned UPIC_SETTLE_CYCLES = 16;

  typedef enum logic [1:0] {
    UPIC_OFF    = 2'b00,
    UPIC_ON     = 2'b01,
    UPIC_SETTLE = 2'b11
  } upic_pwr_state_t;

  function automatic logic [31:0] upic_zext8(input logic [7:0] v);
    upic_zext8 = {24'h000000, v};
  endfunction : upic_zext8

endpackage : upic_pkg

// [rtl/upic_pwr_seq.sv]
// upic_pwr_seq: power sequencer that tracks whether the usb module is
// running, shutting down, or idle and ready to be enabled again.
// assumes power_on_req comes from a register on the same clock.
`timescale 1ns/100ps
`default_nettype none
module upic_pwr_seq
  import upic_pkg::*;
#(
  parameter int unsigned SETTLE = UPIC_SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // control
  input  wire logic power_on_req,
  // status
  output logic      busy,
  output logic      active
);

  localparam int unsigned CW = $clog2(SETTLE + 1);
  localparam logic [CW-1:0] LOAD = CW'(SETTLE - 1);

  upic_pwr_state_t state_q, state_d;
  logic [CW-1:0]   cnt_q, cnt_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      UPIC_OFF: begin
        if (power_on_req) state_d = UPIC_ON;
      end
      UPIC_ON: begin
        if (!power_on_req) begin
          state_d = UPIC_SETTLE;
          cnt_d   = LOAD;
        end
      end
      UPIC_SETTLE: begin
        // a new enable waits until shutdown has fully settled
        if (cnt_q == '0) state_d = UPIC_OFF;
        else cnt_d = cnt_q - CW'(1);
      end
      default: state_d = UPIC_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= UPIC_OFF;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign busy   = (state_q != UPIC_OFF);
  assign active = (state_q == UPIC_ON);

  a_settle_ends: assert property (@(posedge clk) disable iff (reset)
    (state_q == UPIC_SETTLE && cnt_q == '0) |=> !busy)
    else $error("busy did not clear after settle");

endmodule : upic_pwr_seq
`default_nettype wire

// [rtl/upic_ctrl.sv]
// upic_ctrl: apb register block for usb power, suspend, sleep guard,
// interrupt enables and sticky interrupt status.
// assumes event inputs are one-cycle pulses on clk; bus_activity is
// an asynchronous level from the transceiver.
`timescale 1ns/100ps
`default_nettype none
module upic_ctrl
  import upic_pkg::*;
#(
  parameter int unsigned SETTLE = UPIC_SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // usb core events
  input  wire logic [7:1]  usb_events,
  input  wire logic        bus_reset_evt,
  input  wire logic        detach_evt,
  // transceiver
  input  wire logic        bus_activity,
  // power and clock control
  output logic             usb_clk_en,
  output logic             xcvr_low_power,
  output logic             usb_pins_en,
  output logic             analog_en,
  output logic             usb_outputs_en,
  output logic             sleep_block,
  // interrupt
  output logic             combined_usb_irq
);

  // register state
  logic        power_on_q, power_on_d;
  logic        susp_q, susp_d;
  logic        guard_q, guard_d;
  logic        host_q, host_d;
  logic [7:0]  ie_q, ie_d;
  logic [7:0]  stat_q, stat_d;
  logic        pend_q, pend_d;
  logic [31:0] rdata_q, rdata_d;

  // registered outputs
  logic        clk_en_q, clk_en_d;
  logic        lowp_q, lowp_d;
  logic        run_q, run_d;
  logic        sleep_q, sleep_d;

  // activity synchroniser
  logic        act1_q, act2_q, act3_q;

  // sequencer
  logic        busy;
  logic        active;

  // decode
  logic        acc;
  logic        wr;
  logic        rd_setup;
  logic        mapped;
  logic        locked;
  logic        act_rise;
  logic [7:0]  evt;
  logic [7:0]  stat_clr;
  logic [31:0] pwr_view;

  upic_pwr_seq #(
    .SETTLE (SETTLE)
  ) u_seq (
    .clk          (clk),
    .reset        (reset),
    .power_on_req (power_on_q),
    .busy         (busy),
    .active       (active)
  );

  // apb decode; zero wait states, read data captured in setup
  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped   = (paddr == UPIC_PWR_CTRL_OFF) |
                    (paddr == UPIC_IRQ_EN_OFF)   |
                    (paddr == UPIC_IRQ_STAT_OFF) |
                    (paddr == UPIC_MODE_OFF);
  assign pready   = 1'b1;
  assign pslverr  = acc & ~mapped;
  assign prdata   = rdata_q;

  // power-off requested and shutdown not finished: writes to other registers are dropped
  assign locked = ~power_on_q & busy;

  // bit 0 source follows the role
  assign evt = {usb_events,
                host_q ? detach_evt : bus_reset_evt};

  assign act_rise = act2_q & ~act3_q;

  always_comb begin
    pwr_view = '0;
    pwr_view[UPIC_PWR_ON_BIT] = power_on_q;
    pwr_view[UPIC_SUSP_BIT]   = susp_q;
    pwr_view[UPIC_BUSY_BIT]   = busy;
    pwr_view[UPIC_GUARD_BIT]  = guard_q;
    pwr_view[UPIC_PEND_BIT]   = pend_q;
  end

  // register writes
  always_comb begin
    power_on_d = power_on_q;
    susp_d     = susp_q;
    guard_d    = guard_q;
    host_d     = host_q;
    ie_d       = ie_q;
    stat_clr   = '0;
    if (wr && paddr == UPIC_PWR_CTRL_OFF) begin
      power_on_d = pwdata[UPIC_PWR_ON_BIT];
      susp_d     = pwdata[UPIC_SUSP_BIT];
      guard_d    = pwdata[UPIC_GUARD_BIT];
    end
    if (wr && !locked) begin
      if (paddr == UPIC_IRQ_EN_OFF) ie_d = pwdata[7:0];
      if (paddr == UPIC_MODE_OFF) host_d = pwdata[UPIC_HOST_BIT];
      if (paddr == UPIC_IRQ_STAT_OFF) stat_clr = pwdata[7:0];
    end
    // set wins over write-one-to-clear; enables do not gate recording
    stat_d = (stat_q & ~stat_clr) | (evt & {8{active}});
  end

  // activity pending: seen during suspend, cleared when resumed
  always_comb begin
    pend_d = (pend_q | act_rise) & susp_q & power_on_q;
  end

  // read data
  always_comb begin
    rdata_d = rdata_q;
    if (rd_setup) begin
      case (paddr)
        UPIC_PWR_CTRL_OFF: rdata_d = pwr_view;
        UPIC_IRQ_EN_OFF:   rdata_d = upic_zext8(ie_q);
        UPIC_IRQ_STAT_OFF: rdata_d = upic_zext8(stat_q);
        UPIC_MODE_OFF:     rdata_d = {31'h00000000, host_q};
        default:           rdata_d = '0;
      endcase
    end
  end

  // module-side controls
  always_comb begin
    run_d    = active;
    clk_en_d = active & ~susp_q;
    lowp_d   = ~active | susp_q;
    sleep_d  = guard_q & (act2_q | pend_q | combined_usb_irq);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      power_on_q <= UPIC_BIT_RST;
      susp_q     <= UPIC_BIT_RST;
      guard_q    <= UPIC_BIT_RST;
      host_q     <= UPIC_BIT_RST;
      ie_q       <= UPIC_EVT_RST;
      stat_q     <= UPIC_EVT_RST;
      pend_q     <= UPIC_BIT_RST;
      rdata_q    <= '0;
      run_q      <= 1'b0;
      clk_en_q   <= 1'b0;
      lowp_q     <= 1'b1;
      sleep_q    <= 1'b0;
      act1_q     <= 1'b0;
      act2_q     <= 1'b0;
      act3_q     <= 1'b0;
    end else begin
      power_on_q <= power_on_d;
      susp_q     <= susp_d;
      guard_q    <= guard_d;
      host_q     <= host_d;
      ie_q       <= ie_d;
      stat_q     <= stat_d;
      pend_q     <= pend_d;
      rdata_q    <= rdata_d;
      run_q      <= run_d;
      clk_en_q   <= clk_en_d;
      lowp_q     <= lowp_d;
      sleep_q    <= sleep_d;
      act1_q     <= bus_activity;
      act2_q     <= act1_q;
      act3_q     <= act2_q;
    end
  end

  assign usb_clk_en     = clk_en_q;
  assign xcvr_low_power = lowp_q;
  assign usb_pins_en    = run_q;
  assign analog_en      = run_q;
  assign usb_outputs_en = run_q;
  assign sleep_block    = sleep_q;

  // each status bit reaches the line only through its enable
  assign combined_usb_irq = |(stat_q & ie_q);

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_pwr_read;
    rd_setup && paddr == UPIC_PWR_CTRL_OFF;
  endsequence

  sequence s_enable_from_idle;
    $rose(power_on_q) && !busy;
  endsequence

  a_enable_runs: assert property (
    s_enable_from_idle |-> ##2 usb_outputs_en ##0 usb_pins_en)
    else $error("module not running two cycles after enable");

  a_off_idle: assert property (
    !active |=> !usb_outputs_en && !usb_pins_en && !analog_en)
    else $error("outputs driven while module is off");

  a_suspend_gates: assert property (
    susp_q |=> !usb_clk_en && xcvr_low_power)
    else $error("usb clock not gated in suspend");

  a_busy_held: assert property (
    $fell(power_on_q) |-> busy ##1 busy)
    else $error("busy dropped at start of shutdown");

  a_busy_read: assert property (
    s_pwr_read |=> prdata[UPIC_BUSY_BIT] == $past(busy))
    else $error("busy bit read wrong");

  a_locked_write: assert property (
    wr && locked && paddr == UPIC_IRQ_EN_OFF |=> $stable(ie_q))
    else $error("enable written while shutting down");

  a_guard_blocks: assert property (
    guard_q && (pend_q || act2_q) |=> sleep_block)
    else $error("sleep not blocked with guard set");

  a_guard_off: assert property (
    !guard_q |=> !sleep_block)
    else $error("sleep blocked with guard clear");

  a_pend_set: assert property (
    act_rise && susp_q && power_on_q |=> pend_q ##1
      (pend_q || !$past(susp_q && power_on_q)))
    else $error("activity pending not recorded");

  a_resv_zero: assert property (
    s_pwr_read |=> prdata[31:8] == 24'h000000 && prdata[6:5] == 2'b00
                   && !prdata[2])
    else $error("reserved power bits not zero");

  a_ie_reset: assert property (
    $fell(reset) |-> ie_q == UPIC_EVT_RST)
    else $error("enables not zero after reset");

  a_detach_host: assert property (
    host_q && detach_evt && active |=> stat_q[UPIC_RST_BIT])
    else $error("detach not recorded in host mode");

  a_err_masked: assert property (
    !ie_q[UPIC_ERR_BIT] && stat_q == 8'h02 |-> !combined_usb_irq)
    else $error("masked error raised interrupt");

  a_event_kept: assert property (
    active && usb_events[UPIC_ERR_BIT] && !ie_q[UPIC_ERR_BIT]
      |=> stat_q[UPIC_ERR_BIT])
    else $error("masked event not recorded");

  a_clk_resume: assert property (
    active && !susp_q |=> usb_clk_en && !xcvr_low_power)
    else $error("usb clock not restored after suspend");

  a_ie_write: assert property (
    wr && !locked && paddr == UPIC_IRQ_EN_OFF
      |=> ie_q == $past(pwdata[7:0]))
    else $error("enable write not taken");

  a_pend_clear: assert property (
    !susp_q || !power_on_q |=> !pend_q)
    else $error("activity pending kept after resume");

endmodule : upic_ctrl
`default_nettype wire

// [bench/upic_xcvr_model.sv]
// upic_xcvr_model: far side of the usb block, core event pulses and
// transceiver bus activity, driven on command from the bench tasks.
// assumes the same clk as the block under test.
`timescale 1ns/100ps
`default_nettype none
module upic_xcvr_model (
  // clock
  input  wire logic       clk,
  // events and activity
  output logic [7:1]      usb_events,
  output logic            bus_reset_evt,
  output logic            detach_evt,
  output logic            bus_activity
);
  initial begin
    usb_events    = 7'h00;
    bus_reset_evt = 1'b0;
    detach_evt    = 1'b0;
    bus_activity  = 1'b0;
  end

  // one-cycle pulse; m[8] is detach, m[0] bus reset
  task pulse(input logic [8:0] m);
    @(posedge clk);
    usb_events    <= m[7:1];
    bus_reset_evt <= m[0];
    detach_evt    <= m[8];
    @(posedge clk);
    usb_events    <= 7'h00;
    bus_reset_evt <= 1'b0;
    detach_evt    <= 1'b0;
  endtask : pulse

  // activity is a level on the bus, not tied to frames
  task act(input logic v);
    @(posedge clk);
    bus_activity <= v;
  endtask : act
endmodule : upic_xcvr_model
`default_nettype wire

// [bench/tb_usb_power_and_irq_enable_ctrl.sv]
// tb_usb_power_and_irq_enable_ctrl: apb-driven checks of power,
// suspend, guard, pending, enables and sticky status.
// assumes a short settle count so power-down finishes quickly.
`timescale 1ns/100ps
`default_nettype none
module tb_usb_power_and_irq_enable_ctrl;
  import upic_pkg::*;
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:1]  usb_events;
  logic        bus_reset_evt;
  logic        detach_evt;
  logic        bus_activity;
  logic        usb_clk_en;
  logic        xcvr_low_power;
  logic        usb_pins_en;
  logic        analog_en;
  logic        usb_outputs_en;
  logic        sleep_block;
  logic        combined_usb_irq;
  logic [31:0] rd;
  logic        er;
  int          errors;
  int          checks;
  int          cycles;

  upic_ctrl #(.SETTLE(8)) u_dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .usb_events(usb_events),
    .bus_reset_evt(bus_reset_evt), .detach_evt(detach_evt),
    .bus_activity(bus_activity), .usb_clk_en(usb_clk_en),
    .xcvr_low_power(xcvr_low_power), .usb_pins_en(usb_pins_en),
    .analog_en(analog_en), .usb_outputs_en(usb_outputs_en),
    .sleep_block(sleep_block), .combined_usb_irq(combined_usb_irq)
  );

  upic_xcvr_model u_xcvr (
    .clk(clk), .usb_events(usb_events), .bus_reset_evt(bus_reset_evt),
    .detach_evt(detach_evt), .bus_activity(bus_activity)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task conclude;
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // generous ceiling; the sequence needs a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks = checks + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk

  // outputs are looked at mid-cycle, after the edge has settled
  task idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : idle

  initial begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; errors = 0; checks = 0; cycles = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rchk(UPIC_PWR_CTRL_OFF, 32'h0);
    rchk(UPIC_IRQ_EN_OFF, 32'h0);
    chk({usb_outputs_en, analog_en, usb_pins_en, xcvr_low_power}, 4'h1);
    xfer(1'b1, UPIC_IRQ_EN_OFF, 32'hFFFFFFFF);
    rchk(UPIC_IRQ_EN_OFF, 32'h000000FF);
    xfer(1'b1, UPIC_IRQ_EN_OFF, 32'h0);
    xfer(1'b1, UPIC_PWR_CTRL_OFF, 32'hFFFFFFFF);
    idle(4);
    chk({usb_outputs_en, analog_en, usb_pins_en}, 3'h7);
    chk({usb_clk_en, xcvr_low_power}, 2'h1);
    rchk(UPIC_PWR_CTRL_OFF, 32'h0000001B);
    u_xcvr.act(1'b1);
    idle(6);
    rchk(UPIC_PWR_CTRL_OFF, 32'h0000009B);
    chk(sleep_block, 1'b1);
    xfer(1'b1, UPIC_PWR_CTRL_OFF, 32'h3);
    idle(3);
    chk(sleep_block, 1'b0);
    xfer(1'b1, UPIC_PWR_CTRL_OFF, 32'h1);
    u_xcvr.act(1'b0);
    idle(3);
    chk({usb_clk_en, xcvr_low_power}, 2'h2);
    rchk(UPIC_PWR_CTRL_OFF, 32'h00000009);
    for (int i = 1; i < 8; i++) begin
      u_xcvr.pulse(9'(1 << i));
      idle(2);
      rchk(UPIC_IRQ_STAT_OFF, 32'(1 << i));
      chk(combined_usb_irq, 1'b0);
      xfer(1'b1, UPIC_IRQ_STAT_OFF, 32'hFF);
    end
    u_xcvr.pulse(9'h002);
    xfer(1'b1, UPIC_IRQ_EN_OFF, 32'hFD);
    idle(1);
    chk(combined_usb_irq, 1'b0);
    xfer(1'b1, UPIC_IRQ_EN_OFF, 32'h02);
    idle(1);
    chk(combined_usb_irq, 1'b1);
    xfer(1'b1, UPIC_IRQ_STAT_OFF, 32'h02);
    idle(1);
    chk(combined_usb_irq, 1'b0);
    // bit 0 source follows the mode: device then host
    for (int m = 0; m < 2; m++) begin
      xfer(1'b1, UPIC_MODE_OFF, 32'(m));
      u_xcvr.pulse(m ? 9'h001 : 9'h100);
      idle(2);
      rchk(UPIC_IRQ_STAT_OFF, 32'h0);
      u_xcvr.pulse(m ? 9'h100 : 9'h001);
      idle(2);
      rchk(UPIC_IRQ_STAT_OFF, 32'h1);
      xfer(1'b1, UPIC_IRQ_STAT_OFF, 32'h1);
    end
    xfer(1'b0, 12'h010, 32'h0);
    chk(er, 1'b1);
    xfer(1'b1, UPIC_PWR_CTRL_OFF, 32'h0);
    rchk(UPIC_PWR_CTRL_OFF, 32'h00000008);
    // still settling: this enable write must be dropped
    xfer(1'b1, UPIC_IRQ_EN_OFF, 32'hFF);
    idle(10);
    rchk(UPIC_PWR_CTRL_OFF, 32'h0);
    rchk(UPIC_IRQ_EN_OFF, 32'h00000002);
    chk({usb_outputs_en, analog_en, usb_pins_en, xcvr_low_power}, 4'h1);
    // second reset in mid-run clears the enables again
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rchk(UPIC_IRQ_EN_OFF, 32'h0);
    rchk(UPIC_PWR_CTRL_OFF, 32'h0);
    conclude();
  end
endmodule : tb_usb_power_and_irq_enable_ctrl
`default_nettype wire
